//--- shared/pld_pkg.sv
/*
  Shared constants for the logic group model: group geometry, routing
  widths, product-term destinations, flip-flop types and clock modes.
  Assumes configuration cells are static while the model runs.
*/
`default_nettype none

package pld_pkg;

  // group geometry
  localparam int MC_COUNT     = 16;
  localparam int GROUP_IN     = 36;
  localparam int PT_PER_MC    = 5;
  localparam int SEXP_COUNT   = 16;
  localparam int CHAIN_LEN    = 8;
  localparam int MAX_SETS     = 3;
  localparam int OR_MAX_TERMS = 20;
  localparam int MC_MAX_TERMS = 32;
  localparam int DED_COUNT    = 4;
  localparam int IO_COUNT     = 16;
  localparam int GCLK_COUNT   = 2;

  // dedicated input positions
  localparam int DED_GCLK_A   = 0;
  localparam int DED_GCLR_N   = 1;
  localparam int DED_OE_A_N   = 2;
  localparam int DED_GCLK_B   = 3;

  // AND array width: true and complement of inputs and expanders
  localparam int ARRAY_W      = 2 * (GROUP_IN + SEXP_COUNT);
  localparam int SEXP_W       = 2 * GROUP_IN;
  localparam int SEXP_PAD     = ARRAY_W - SEXP_W;

  // product-term destinations
  localparam int ROUTE_W            = 3;
  localparam logic [2:0] ROUTE_OR   = 3'h0;
  localparam logic [2:0] ROUTE_AUX  = 3'h1;
  localparam logic [2:0] ROUTE_CLR  = 3'h2;
  localparam logic [2:0] ROUTE_PRE  = 3'h3;
  localparam logic [2:0] ROUTE_CLK  = 3'h4;
  localparam logic [2:0] ROUTE_ENA  = 3'h5;

  // flip-flop types
  localparam int FF_W           = 2;
  localparam logic [1:0] FF_D   = 2'h0;
  localparam logic [1:0] FF_T   = 2'h1;
  localparam logic [1:0] FF_JK  = 2'h2;
  localparam logic [1:0] FF_SR  = 2'h3;

  // clocking modes
  localparam int CLKM_W              = 2;
  localparam logic [1:0] CLKM_GLOBAL = 2'h0;
  localparam logic [1:0] CLKM_GATED  = 2'h1;
  localparam logic [1:0] CLKM_ARRAY  = 2'h2;

  // parallel expander borrow depth field
  localparam int DEPTH_W = 2;

  // power-up values
  localparam logic REG_RESET   = 1'b0;
  localparam logic ROUTE_RESET = 1'b0;

endpackage

`default_nettype wire

//--- design/macrocell_reg.sv
/*
  One macrocell register: clock source selection, edge detection,
  D/T/JK/SR behaviour, preset/clear and combinational bypass.
  Assumes all control inputs are synchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module macrocell_reg
  import pld_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic [CLKM_W-1:0] clk_mode,
  input  wire logic [FF_W-1:0]   ff_type,
  input  wire logic              reg_bypass,
  input  wire logic              fast_en,
  input  wire logic              fast_d,
  input  wire logic              gclk_level,
  input  wire logic              pt_clk,
  input  wire logic              pt_ena,
  input  wire logic              pt_pre,
  input  wire logic              pt_clr,
  input  wire logic              gclr_hit,
  input  wire logic              sum,
  input  wire logic              aux,
  input  wire logic              pol,
  output logic                   mc_out
);

  logic state_ff;
  logic clk_prev_ff;
  logic clk_level;
  logic clk_edge;
  logic clk_ok;
  logic comb_val;
  logic nxt_state;

  // clock source and enable per mode
  always_comb begin
    clk_level = gclk_level;
    clk_ok    = 1'b1;
    case (clk_mode)
      CLKM_GLOBAL: clk_level = gclk_level;
      CLKM_GATED: begin
        clk_level = gclk_level;
        clk_ok    = pt_ena;
      end
      CLKM_ARRAY: clk_level = pt_clk;
      default: clk_level = gclk_level;
    endcase
  end

  // rising edge of the chosen clock
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      clk_prev_ff <= REG_RESET;
    end else begin
      clk_prev_ff <= clk_level;
    end
  end

  assign clk_edge = clk_level & ~clk_prev_ff;
  assign comb_val = sum ^ aux ^ pol;

  // next state by flip-flop type
  always_comb begin
    nxt_state = state_ff;
    if (fast_en) begin
      nxt_state = fast_d;
    end else begin
      case (ff_type)
        FF_D:  nxt_state = comb_val;
        FF_T:  nxt_state = state_ff ^ comb_val;
        FF_JK: nxt_state = (sum & ~state_ff) | (~aux & state_ff);
        FF_SR: nxt_state = sum | (~aux & state_ff);
        default: nxt_state = comb_val;
      endcase
    end
  end

  // clear beats preset beats clock
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_ff <= REG_RESET;
    end else if (pt_clr || gclr_hit) begin
      state_ff <= 1'b0;
    end else if (pt_pre) begin
      state_ff <= 1'b1;
    end else if (clk_edge && clk_ok) begin
      state_ff <= nxt_state;
    end
  end

  // bypass gives a purely combinational output
  assign mc_out = reg_bypass ? comb_val : state_ff;

endmodule

`default_nettype wire

//--- design/pld_logic_group.sv
/*
  One logic group of a product-term programmable logic device: input
  selection from the global routing bus, AND array, product-term select
  matrix, shareable and parallel expanders, and sixteen macrocells.
  Assumes configuration cells are static inputs and that every pin input
  is synchronous to ref_clk; asynchronous controls act on the next edge.
*/
// Function
// - sixteen macrocells form one logic group
// - thirty-six bus inputs plus global controls
// - five programmable product terms per macrocell
// - select matrix routes terms to logic/controls
// - sixteen inverted shareable expanders fed back
// - OR takes own five plus fifteen borrowed
// - borrowing only downward inside chains of eight
// - chain bottom only lends, top only borrows
// - expanders together give up to 32 terms
// - register acts as D, T, JK, SR or bypass
// - global, gated global or array clock modes
// - one or two selectable global clocks
// - active-high product-term preset and clear
// - optional active-low global clear pin per register
// - registers power up low
// - fast pin path into register D input
// - bus input gated by configuration AND
// - four dedicated inputs as data or controls
// - fixed equal delay for all routed inputs
`timescale 1ns/1ps
`default_nettype none

module pld_logic_group
  import pld_pkg::*;
#(
  parameter bit EXTENDED  = 1'b1,
  parameter int EXT_BUS_W = 32,
  parameter int SEL_W     = 7
)(
  input  wire logic                            ref_clk,
  input  wire logic                            rstn,
  input  wire logic [DED_COUNT-1:0]            dedicated_in,
  input  wire logic [IO_COUNT-1:0]             io_pin_in,
  input  wire logic [EXT_BUS_W-1:0]            ext_bus_in,
  input  wire logic [GROUP_IN*SEL_W-1:0]       route_sel,
  input  wire logic [GROUP_IN-1:0]             route_en,
  input  wire logic [MC_COUNT*PT_PER_MC*ARRAY_W-1:0] pt_mask,
  input  wire logic [MC_COUNT*PT_PER_MC*ROUTE_W-1:0] pt_route,
  input  wire logic [SEXP_COUNT*SEXP_W-1:0]    sexp_mask,
  input  wire logic [MC_COUNT-1:0]             xor_pol,
  input  wire logic [MC_COUNT-1:0]             lend_en,
  input  wire logic [MC_COUNT*DEPTH_W-1:0]     borrow_depth,
  input  wire logic [MC_COUNT*FF_W-1:0]        ff_type,
  input  wire logic [MC_COUNT-1:0]             reg_bypass,
  input  wire logic [MC_COUNT*CLKM_W-1:0]      clk_mode,
  input  wire logic [MC_COUNT-1:0]             gclk_sel,
  input  wire logic [GCLK_COUNT-1:0]           gclk_src_b,
  input  wire logic [GCLK_COUNT-1:0]           gclk_inv,
  input  wire logic [MC_COUNT-1:0]             gclr_en,
  input  wire logic [MC_COUNT-1:0]             fast_in_en,
  output logic [MC_COUNT-1:0]                  mc_out,
  output logic [GROUP_IN-1:0]                  group_in_out
);

  localparam int BUS_W = EXT_BUS_W + DED_COUNT + IO_COUNT + MC_COUNT;

  // evaluate one product term; an empty mask gives a low term
  function automatic logic pt_eval(
    input logic [ARRAY_W-1:0] mask,
    input logic [ARRAY_W-1:0] vec
  );
    logic hit;
    hit = (|mask) & (&(~mask | vec));
    return hit;
  endfunction

  // pick one bus signal and gate it with its enable cell
  function automatic logic bus_pick(
    input logic [BUS_W-1:0] bus,
    input logic [SEL_W-1:0] sel,
    input logic             en
  );
    logic bit_val;
    bit_val = 1'b0;
    if (int'(sel) < BUS_W) begin
      bit_val = bus[sel];
    end
    return bit_val & en;
  endfunction

  // depth actually allowed at a chain position
  function automatic int eff_depth(
    input logic [DEPTH_W-1:0] depth,
    input int                 pos
  );
    int d;
    d = int'(depth);
    if (d > MAX_SETS) begin
      d = MAX_SETS;
    end
    if (d > pos) begin
      d = pos;
    end
    return d;
  endfunction

  logic [BUS_W-1:0]      full_bus;
  logic [GROUP_IN-1:0]   routed_ff;
  logic [GROUP_IN-1:0]   nxt_routed;
  logic [SEXP_COUNT-1:0] sexp;
  logic [ARRAY_W-1:0]    array_vec;
  logic [ARRAY_W-1:0]    sexp_vec;
  logic [MC_COUNT-1:0]   local_or;
  logic [MC_COUNT-1:0]   aux_term;
  logic [MC_COUNT-1:0]   clr_term;
  logic [MC_COUNT-1:0]   pre_term;
  logic [MC_COUNT-1:0]   clk_term;
  logic [MC_COUNT-1:0]   ena_term;
  logic [MC_COUNT-1:0]   can_lend;
  logic [MC_COUNT-1:0]   lent_set;
  logic [MC_COUNT-1:0]   borrowed;
  logic [MC_COUNT-1:0]   or_sum;
  logic [GCLK_COUNT-1:0] gclk;
  logic                  gclr_level;

  // global bus: all dedicated inputs, pins and macrocell outputs
  assign full_bus = {mc_out, io_pin_in, dedicated_in, ext_bus_in};

  // each group input is a bus signal ANDed with its cell
  always_comb begin
    for (int g = 0; g < GROUP_IN; g++) begin
      nxt_routed[g] = bus_pick(full_bus, route_sel[g*SEL_W +: SEL_W],
                               route_en[g]);
    end
  end

  // one register stage on every routed input: equal delay, no skew
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      routed_ff <= {GROUP_IN{ROUTE_RESET}};
    end else begin
      routed_ff <= nxt_routed;
    end
  end

  assign group_in_out = routed_ff;

  // shareable expanders see only the routed inputs
  assign sexp_vec = {{SEXP_PAD{1'b0}}, ~routed_ff, routed_ff};

  // inverted expander terms, one per macrocell
  always_comb begin
    for (int j = 0; j < SEXP_COUNT; j++) begin
      sexp[j] = ~pt_eval({{SEXP_PAD{1'b0}},
                          sexp_mask[j*SEXP_W +: SEXP_W]},
                         sexp_vec);
    end
  end

  // AND array inputs: true and complement of inputs and expanders
  assign array_vec = {~sexp, sexp, ~routed_ff, routed_ff};

  // product-term select matrix per macrocell
  always_comb begin
    logic                term;
    logic [ROUTE_W-1:0]  dest;
    int                  idx;
    term = 1'b0;
    dest = ROUTE_OR;
    idx  = 0;
    local_or = '0;
    aux_term = '0;
    clr_term = '0;
    pre_term = '0;
    clk_term = '0;
    ena_term = '0;
    for (int i = 0; i < MC_COUNT; i++) begin
      for (int t = 0; t < PT_PER_MC; t++) begin
        idx  = i * PT_PER_MC + t;
        term = pt_eval(pt_mask[idx*ARRAY_W +: ARRAY_W], array_vec);
        dest = pt_route[idx*ROUTE_W +: ROUTE_W];
        case (dest)
          ROUTE_OR:  local_or[i] = local_or[i] | term;
          ROUTE_AUX: aux_term[i] = aux_term[i] | term;
          ROUTE_CLR: clr_term[i] = clr_term[i] | term;
          ROUTE_PRE: pre_term[i] = pre_term[i] | term;
          ROUTE_CLK: clk_term[i] = clk_term[i] | term;
          ROUTE_ENA: ena_term[i] = ena_term[i] | term;
          default:   local_or[i] = local_or[i];
        endcase
      end
    end
  end

  // lending: the top of each chain never lends its terms
  always_comb begin
    for (int i = 0; i < MC_COUNT; i++) begin
      can_lend[i] = lend_en[i] & ((i % CHAIN_LEN) != CHAIN_LEN - 1);
      lent_set[i] = can_lend[i] & local_or[i];
    end
  end

  // borrowing: up to three sets from the next lower cells of the chain
  always_comb begin
    int d;
    int pos;
    d   = 0;
    pos = 0;
    borrowed = '0;
    for (int i = 0; i < MC_COUNT; i++) begin
      pos = i % CHAIN_LEN;
      d   = eff_depth(borrow_depth[i*DEPTH_W +: DEPTH_W], pos);
      for (int k = 1; k <= MAX_SETS; k++) begin
        if (k <= d && i >= k) begin
          borrowed[i] = borrowed[i] | lent_set[i-k];
        end
      end
    end
  end

  // OR gate: own terms unless lent, plus borrowed sets
  always_comb begin
    for (int i = 0; i < MC_COUNT; i++) begin
      or_sum[i] = (local_or[i] & ~can_lend[i]) | borrowed[i];
    end
  end

  // global clocks: pin a only, or either pin true or complemented
  always_comb begin
    for (int g = 0; g < GCLK_COUNT; g++) begin
      if (EXTENDED) begin
        gclk[g] = (gclk_src_b[g] ? dedicated_in[DED_GCLK_B]
                                 : dedicated_in[DED_GCLK_A])
                  ^ gclk_inv[g];
      end else begin
        gclk[g] = dedicated_in[DED_GCLK_A];
      end
    end
  end

  // global clear pin is active low
  assign gclr_level = ~dedicated_in[DED_GCLR_N];

  // sixteen macrocell registers make up the group
  for (genvar i = 0; i < MC_COUNT; i++) begin : g_mc
    logic gclk_mc;
    logic fast_mc;

    assign gclk_mc = EXTENDED ? gclk[gclk_sel[i]] : gclk[0];
    assign fast_mc = EXTENDED ? fast_in_en[i] : 1'b0;

    macrocell_reg u_reg (
      .ref_clk    (ref_clk),
      .rstn       (rstn),
      .clk_mode   (clk_mode[i*CLKM_W +: CLKM_W]),
      .ff_type    (ff_type[i*FF_W +: FF_W]),
      .reg_bypass (reg_bypass[i]),
      .fast_en    (fast_mc),
      .fast_d     (io_pin_in[i]),
      .gclk_level (gclk_mc),
      .pt_clk     (clk_term[i]),
      .pt_ena     (ena_term[i]),
      .pt_pre     (pre_term[i]),
      .pt_clr     (clr_term[i]),
      .gclr_hit   (gclr_level & gclr_en[i]),
      .sum        (or_sum[i]),
      .aux        (aux_term[i]),
      .pol        (xor_pol[i]),
      .mc_out     (mc_out[i])
    );
  end

endmodule

`default_nettype wire

//--- tb/pld_group_asserts.sv
/*
  Checker for the logic group ports: reset, routing and register rules.
  Assumes configuration inputs stay static while rstn is high.
*/
`timescale 1ns/1ps
`default_nettype none

module pld_group_asserts
  import pld_pkg::*;
#(
  parameter int EXT_BUS_W = 32,
  parameter int SEL_W     = 7
)(
  input wire logic                              ref_clk,
  input wire logic                              rstn,
  input wire logic [DED_COUNT-1:0]              dedicated_in,
  input wire logic [IO_COUNT-1:0]               io_pin_in,
  input wire logic [EXT_BUS_W-1:0]              ext_bus_in,
  input wire logic [GROUP_IN*SEL_W-1:0]         route_sel,
  input wire logic [GROUP_IN-1:0]               route_en,
  input wire logic [MC_COUNT*PT_PER_MC*ROUTE_W-1:0] pt_route,
  input wire logic [MC_COUNT-1:0]               reg_bypass,
  input wire logic [MC_COUNT*CLKM_W-1:0]        clk_mode,
  input wire logic [MC_COUNT-1:0]               gclk_sel,
  input wire logic [GCLK_COUNT-1:0]             gclk_src_b,
  input wire logic [GCLK_COUNT-1:0]             gclk_inv,
  input wire logic [MC_COUNT-1:0]               gclr_en,
  input wire logic [MC_COUNT-1:0]               mc_out,
  input wire logic [GROUP_IN-1:0]               group_in_out
);
  localparam int BUS_N = EXT_BUS_W + DED_COUNT + IO_COUNT + MC_COUNT;
  wire logic [BUS_N-1:0] bus = {mc_out, io_pin_in, dedicated_in, ext_bus_in};
  logic [GROUP_IN-1:0] exp_ff;
  logic                no_ctl0;
  wire logic           quiet0;

  // expected group inputs, one stage behind the bus
  always_ff @(posedge ref_clk) begin
    for (int g = 0; g < GROUP_IN; g++) begin
      if (!rstn || !route_en[g] || route_sel[g*SEL_W+:SEL_W] >= BUS_N)
        exp_ff[g] <= 1'b0;
      else
        exp_ff[g] <= bus[route_sel[g*SEL_W+:SEL_W]];
    end
  end

  // cell 0 has no product-term preset or clear
  always_comb begin
    no_ctl0 = 1'b1;
    for (int t = 0; t < PT_PER_MC; t++)
      if (pt_route[t*ROUTE_W+:ROUTE_W] inside {ROUTE_CLR, ROUTE_PRE})
        no_ctl0 = 1'b0;
  end
  // cell 0 clocked by true pin a, no global clear
  assign quiet0 = no_ctl0 && !reg_bypass[0] && !gclr_en[0] && !gclk_sel[0]
    && !gclk_src_b[0] && !gclk_inv[0]
    && !(clk_mode[CLKM_W-1:0] inside {CLKM_GATED, CLKM_ARRAY});

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence clr_held;
    !dedicated_in[DED_GCLR_N] [*2];
  endsequence
  sequence pin_high2;
    (rstn && dedicated_in[DED_GCLK_A]) ##1 (dedicated_in[DED_GCLK_A] && quiet0);
  endsequence

  a_reset_low: assert property (disable iff (1'b0)
    !rstn |=> (mc_out & ~reg_bypass) == '0) else $error("register not low");
  a_reset_gin: assert property (disable iff (1'b0)
    !rstn |=> group_in_out == '0) else $error("group input not low");
  a_route_gate: assert property (
    rstn |=> (group_in_out & ~$past(route_en)) == '0)
    else $error("disabled group input not low");
  a_route_match: assert property (
    group_in_out == exp_ff) else $error("group input wrong source");
  a_gclr_clear: assert property (
    !dedicated_in[DED_GCLR_N] |=> (mc_out & $past(gclr_en) & ~reg_bypass) == '0)
    else $error("global clear ignored");
  a_clr_held: assert property (
    clr_held |-> (mc_out & gclr_en & ~reg_bypass) == '0)
    else $error("held clear ignored");
  a_hold_no_edge: assert property (
    $past(rstn) && quiet0 && !(dedicated_in[DED_GCLK_A]
    && !$past(dedicated_in[DED_GCLK_A])) |=> $stable(mc_out[0]))
    else $error("register changed without edge");
  a_high_no_reedge: assert property (
    pin_high2 |=> $stable(mc_out[0])) else $error("level clocked twice");
endmodule

bind pld_logic_group pld_group_asserts #(
  .EXT_BUS_W(EXT_BUS_W),
  .SEL_W    (SEL_W)
) u_chk (
  .ref_clk(ref_clk), .rstn(rstn), .dedicated_in(dedicated_in),
  .io_pin_in(io_pin_in), .ext_bus_in(ext_bus_in), .route_sel(route_sel),
  .route_en(route_en), .pt_route(pt_route), .reg_bypass(reg_bypass),
  .clk_mode(clk_mode), .gclk_sel(gclk_sel), .gclk_src_b(gclk_src_b),
  .gclk_inv(gclk_inv), .gclr_en(gclr_en), .mc_out(mc_out),
  .group_in_out(group_in_out)
);

`default_nettype wire

//--- tb/pin_side.sv
/*
  Pin and bus side model: dedicated inputs, I/O pins, other bus sources.
  Assumes requests from the bench change just after a ref_clk edge.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_side (
  input  wire logic        ref_clk,
  input  wire logic [1:0]  data_req,
  input  wire logic        clk_req,
  input  wire logic        clr_req,
  output logic [3:0]       dedicated_in,
  output logic [15:0]      io_pin_in,
  output logic [31:0]      ext_bus_in
);
  logic [1:0] cnt_ff = 2'h0;

  // free-running pattern keeps unused pins moving
  always_ff @(posedge ref_clk) begin
    cnt_ff <= cnt_ff + 2'h1;
  end
  // four dedicated inputs, msb first: clock b, enable a, clear (low), clock a
  assign dedicated_in = {cnt_ff[0], 1'b1, ~clr_req, clk_req};
  assign io_pin_in    = {15'h0, cnt_ff[1]};
  assign ext_bus_in   = {30'h0, data_req};
endmodule

`default_nettype wire

//--- tb/testbench.sv
/*
  Self-checking bench for one logic group: routing, D capture, gated
  hold and global clear. Assumes the package defaults of the design.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench
  import pld_pkg::*;
;
  logic ref_clk = 1'b0, rstn = 1'b0, clk_req = 1'b0, clr_req = 1'b0;
  logic [1:0] data_req = 2'h0;
  logic [3:0] ded;
  logic [15:0] io, mc_out;
  logic [31:0] ext;
  logic [35:0] gin;
  logic [36*7-1:0] route_sel;
  logic [MC_COUNT*PT_PER_MC*ARRAY_W-1:0] pt_mask;
  logic [MC_COUNT*PT_PER_MC*ROUTE_W-1:0] pt_route;
  logic [35:0] route_en = 36'h1f;
  logic [15:0] xor_pol = 16'h0, reg_bypass = 16'h0, gclk_sel = 16'h0;
  logic [15:0] gclr_en = 16'h2, fast_in_en = 16'h0;
  logic [31:0] ff_type = 32'h0, clk_mode = 32'h10;
  int fail_count = 0, checks_done = 0;

  pin_side u_pins (.ref_clk(ref_clk), .data_req(data_req), .clk_req(clk_req),
    .clr_req(clr_req), .dedicated_in(ded), .io_pin_in(io), .ext_bus_in(ext));
  pld_logic_group u_dut (.ref_clk(ref_clk), .rstn(rstn), .dedicated_in(ded),
    .io_pin_in(io), .ext_bus_in(ext), .route_sel(route_sel),
    .route_en(route_en), .pt_mask(pt_mask), .pt_route(pt_route),
    .sexp_mask('0), .xor_pol(xor_pol), .lend_en(16'h0), .borrow_depth(32'h0),
    .ff_type(ff_type), .reg_bypass(reg_bypass), .clk_mode(clk_mode),
    .gclk_sel(gclk_sel), .gclk_src_b(2'h0), .gclk_inv(2'h0),
    .gclr_en(gclr_en), .fast_in_en(fast_in_en),
    .mc_out(mc_out), .group_in_out(gin));

  // clock
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  // clock pin a high for two samples, then low
  task automatic pulse();
    clk_req = 1'b1;
    tick(2);
    clk_req = 1'b0;
    tick(2);
  endtask
  task automatic finish_test();
    $display("fail_count %0d checks_done %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic t_route();
    data_req = 2'h3;
    tick(1);
    chk_bit(gin[0], 1'b1);
    chk_bit(gin[1], 1'b1);
    chk_bit(gin[5], 1'b0);
  endtask
  task automatic t_capture();
    tick(2);
    chk_vec(mc_out, 16'h0);
    pulse();
    chk_vec(mc_out, 16'h7);
    data_req = 2'h0;
    tick(2);
    pulse();
    chk_vec(mc_out, 16'h4);
  endtask
  task automatic t_clear();
    data_req = 2'h3;
    tick(2);
    pulse();
    chk_bit(gin[2], 1'b1);
    clr_req = 1'b1;
    tick(2);
    chk_vec(mc_out, 16'h5);
    clr_req = 1'b0;
    tick(1);
  endtask

  // configuration, reset and scenarios
  initial begin
    route_sel = '0;
    route_sel[7+:7] = 7'h01;
    route_sel[14+:7] = 7'h34;
    route_sel[21+:7] = 7'h24;
    route_sel[28+:7] = 7'h23;
    pt_mask = '0;
    pt_mask[0] = 1'b1;
    pt_mask[5*ARRAY_W] = 1'b1;
    pt_mask[10*ARRAY_W] = 1'b1;
    pt_mask[11*ARRAY_W+1] = 1'b1;
    pt_route = '0;
    pt_route[11*ROUTE_W+:ROUTE_W] = ROUTE_ENA;
    tick(8);
    chk_vec(mc_out, 16'h0);
    rstn = 1'b1;
    tick(1);
    t_route();
    t_capture();
    t_clear();
    finish_test();
  end

  // watchdog
  initial begin
    #300000;
    fail_count++;
    finish_test();
  end
endmodule

`default_nettype wire
